// File: rtl/atic_ctrl_regs.sv
// APB register bank for amplifier drop, tone enables and input pin setup
// Functional notes
// - Byte register at 0x63 holds a five-bit field resetting to 00011, upper three bits read zero.
// - The field is the drop in whole dB, zero none and one a 1 dB drop, used while amp pin asserted.
// - Bit 0 of the tone register at 0x64 turns the first tone generator on or off.
// - Bit 1 turns the second tone generator on or off; upper bits read zero; reset is zero.
// - One pin byte register per pin at 0x87 to 0x95, bits 2..0 writable, bits 7..3 read-only.
// - Bit 2 is pull-up, bit 1 pull-down, bit 0 Schmitt; only bit 0 resets to one at 0x89 and 0x8A.
`timescale 1ns/10ps
`include "atic_params.svh"
module atic_ctrl_regs #(
    parameter int NUM_PINS = `ATIC_NUM_PINS,
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Amplifier protection
    input wire logic ampProtectPin,
    input wire atic_pkg::atic_period_t profileSlewPeriod,
    output atic_pkg::atic_drop_t appliedDrop,
    output logic dropSettled,
    // Tone generators
    output logic firstBeepEnable,
    output logic secondBeepEnable,
    // Input pin pads
    output logic [NUM_PINS-1:0] pullupEnable,
    output logic [NUM_PINS-1:0] pulldownEnable,
    output logic [NUM_PINS-1:0] schmittEnable
);
    import atic_pkg::*;

    // Index decode helpers
    function automatic logic isPinIndex(input atic_index_t idx);
        isPinIndex = (idx >= `ATIC_IDX_PIN_FIRST) && (idx <= `ATIC_IDX_PIN_LAST);
    endfunction : isPinIndex

    function automatic logic [3:0] pinSlot(input atic_index_t idx);
        atic_index_t diff;
        diff = idx - `ATIC_IDX_PIN_FIRST;
        pinSlot = diff[3:0];
    endfunction : pinSlot

    function automatic atic_pin_cfg_t pinResetValue(input int slot);
        atic_index_t idx;
        idx = `ATIC_IDX_PIN_FIRST + atic_index_t'(slot);
        if (idx == `ATIC_IDX_PIN_SCK || idx == `ATIC_IDX_PIN_CS) begin
            pinResetValue = `ATIC_PIN_CLK_RESET;
        end else begin
            pinResetValue = `ATIC_PIN_RESET;
        end
    endfunction : pinResetValue

    // Register state
    atic_drop_t ampDrop;
    atic_drop_t next_ampDrop;
    logic [1:0] toneEnable;
    logic [1:0] next_toneEnable;
    atic_pin_cfg_t pinCfg [NUM_PINS];
    atic_pin_cfg_t next_pinCfg [NUM_PINS];

    // APB answer state
    logic [31:0] readData;
    logic [31:0] next_readData;
    logic accessError;
    logic next_accessError;

    // Amp pin synchroniser
    logic [2:0] ampSync;
    logic [2:0] next_ampSync;
    logic ampActive;
    logic next_ampActive;

    // Address decode
    atic_index_t regIndex;
    logic addrAligned;
    logic addrMapped;
    logic setupPhase;
    logic writeStrobe;

    atic_slew_if slewBus ();

    always_comb begin
        regIndex = paddr[`ATIC_ADDR_IDX_MSB:`ATIC_ADDR_IDX_LSB];
        addrAligned = (paddr[1:0] == 2'h0);
        if (ADDR_W > `ATIC_ADDR_IDX_MSB + 1) begin
            addrAligned = addrAligned && ((paddr >> (`ATIC_ADDR_IDX_MSB + 1)) == '0);
        end
        addrMapped = addrAligned && (regIndex == `ATIC_IDX_AMP_DROP
            || regIndex == `ATIC_IDX_TONE
            || regIndex == `ATIC_IDX_STATUS
            || isPinIndex(regIndex));
        setupPhase = psel && !penable;
        writeStrobe = psel && penable && pwrite && !accessError && pstrb[0];
    end

    // Read data and error captured in setup, presented in access
    always_comb begin
        next_readData = readData;
        next_accessError = accessError;
        if (setupPhase) begin
            next_accessError = !addrMapped;
            next_readData = 32'h0000_0000;
            if (!pwrite && addrMapped) begin
                unique case (1'b1)
                    regIndex == `ATIC_IDX_AMP_DROP:
                        next_readData[`ATIC_DROP_W-1:0] = ampDrop;
                    regIndex == `ATIC_IDX_TONE:
                        next_readData[1:0] = toneEnable;
                    regIndex == `ATIC_IDX_STATUS: begin
                        next_readData[`ATIC_DROP_W-1:0] = slewBus.applied;
                        next_readData[`ATIC_STAT_PIN_BIT] = ampActive;
                        next_readData[`ATIC_STAT_SETTLED_BIT] = slewBus.settled;
                    end
                    default:
                        next_readData[2:0] = pinCfg[pinSlot(regIndex)];
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            readData <= 32'h0000_0000;
            accessError <= 1'b0;
        end else begin
            readData <= next_readData;
            accessError <= next_accessError;
        end
    end

    assign pready = psel && penable;
    assign pslverr = psel && penable && accessError;
    assign prdata = readData;

    // Amplifier drop register
    always_comb begin
        next_ampDrop = ampDrop;
        if (writeStrobe && regIndex == `ATIC_IDX_AMP_DROP) begin
            next_ampDrop = pwdata[`ATIC_DROP_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ampDrop <= `ATIC_DROP_RESET;
        end else begin
            ampDrop <= next_ampDrop;
        end
    end

    // Tone enable register
    always_comb begin
        next_toneEnable = toneEnable;
        if (writeStrobe && regIndex == `ATIC_IDX_TONE) begin
            next_toneEnable[`ATIC_TONE_FIRST_BIT] = pwdata[`ATIC_TONE_FIRST_BIT];
            next_toneEnable[`ATIC_TONE_SECOND_BIT] = pwdata[`ATIC_TONE_SECOND_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            toneEnable <= `ATIC_TONE_RESET;
        end else begin
            toneEnable <= next_toneEnable;
        end
    end

    assign firstBeepEnable = toneEnable[`ATIC_TONE_FIRST_BIT];
    assign secondBeepEnable = toneEnable[`ATIC_TONE_SECOND_BIT];

    // Input pin control registers
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            next_pinCfg[i] = pinCfg[i];
        end
        if (writeStrobe && isPinIndex(regIndex)) begin
            next_pinCfg[pinSlot(regIndex)] = pwdata[2:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                pinCfg[i] <= pinResetValue(i);
            end
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                pinCfg[i] <= next_pinCfg[i];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            pullupEnable[i] = pinCfg[i][`ATIC_PIN_PU_BIT];
            pulldownEnable[i] = pinCfg[i][`ATIC_PIN_PD_BIT];
            schmittEnable[i] = pinCfg[i][`ATIC_PIN_SMT_BIT];
        end
    end

    // Amp pin qualified when second and third stages agree
    always_comb begin
        next_ampSync = {ampSync[1:0], ampProtectPin};
        next_ampActive = ampActive;
        if (ampSync[1] == ampSync[2]) begin
            next_ampActive = ampSync[2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ampSync <= 3'h0;
            ampActive <= 1'b0;
        end else begin
            ampSync <= next_ampSync;
            ampActive <= next_ampActive;
        end
    end

    // Drop applied only while protection pin is asserted
    assign slewBus.target = ampActive ? ampDrop : 5'h00;
    assign slewBus.period = profileSlewPeriod;

    atic_gain_slew slewer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .slewPort(slewBus.slew)
    );

    assign appliedDrop = slewBus.applied;
    assign dropSettled = slewBus.settled;
endmodule : atic_ctrl_regs

// File: rtl/atic_gain_slew.sv
// Ramps the applied attenuation toward its target one dB per tick
`timescale 1ns/10ps
`include "atic_params.svh"
module atic_gain_slew (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Bank side
    atic_slew_if.slew slewPort
);
    import atic_pkg::*;

    atic_period_t tickCount;
    atic_period_t next_tickCount;
    atic_drop_t applied;
    atic_drop_t next_applied;
    logic tick;

    always_comb begin
        tick = (tickCount == '0);
        next_tickCount = tick ? slewPort.period : tickCount - 16'h0001;
        next_applied = applied;
        if (tick && applied < slewPort.target) begin
            next_applied = applied + 5'h01;
        end else if (tick && applied > slewPort.target) begin
            next_applied = applied - 5'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tickCount <= `ATIC_SLEW_PERIOD_RESET;
            applied <= 5'h00;
        end else begin
            tickCount <= next_tickCount;
            applied <= next_applied;
        end
    end

    assign slewPort.applied = applied;
    assign slewPort.settled = (applied == slewPort.target);
endmodule : atic_gain_slew

// File: rtl/atic_params.svh
// Register indices, reset values and field positions of the control bank
`ifndef ATIC_PARAMS_SVH
`define ATIC_PARAMS_SVH

`define ATIC_IDX_STATUS 8'h60
`define ATIC_IDX_AMP_DROP 8'h63
`define ATIC_IDX_TONE 8'h64
`define ATIC_IDX_PIN_FIRST 8'h87
`define ATIC_IDX_PIN_LAST 8'h95
`define ATIC_IDX_PIN_SCK 8'h89
`define ATIC_IDX_PIN_CS 8'h8A
`define ATIC_NUM_PINS 15

`define ATIC_DROP_W 5
`define ATIC_DROP_RESET 5'h03
`define ATIC_TONE_RESET 2'h0
`define ATIC_PIN_RESET 3'h0
`define ATIC_PIN_CLK_RESET 3'h1

`define ATIC_TONE_FIRST_BIT 0
`define ATIC_TONE_SECOND_BIT 1
`define ATIC_PIN_SMT_BIT 0
`define ATIC_PIN_PD_BIT 1
`define ATIC_PIN_PU_BIT 2
`define ATIC_STAT_PIN_BIT 5
`define ATIC_STAT_SETTLED_BIT 6

`define ATIC_ADDR_IDX_LSB 2
`define ATIC_ADDR_IDX_MSB 9
`define ATIC_SLEW_PERIOD_RESET 16'h0000

`endif

// File: rtl/atic_pkg.sv
// Types shared by the control bank modules
package atic_pkg;
    typedef logic [4:0] atic_drop_t;
    typedef logic [2:0] atic_pin_cfg_t;
    typedef logic [7:0] atic_index_t;
    typedef logic [15:0] atic_period_t;
endpackage : atic_pkg

// File: rtl/atic_slew_if.sv
// Signals between the register bank and the gain slewer
`timescale 1ns/10ps
interface atic_slew_if;
    import atic_pkg::*;
    atic_drop_t target;
    atic_period_t period;
    atic_drop_t applied;
    logic settled;
    modport ctrl (output target, output period, input applied, input settled);
    modport slew (input target, input period, output applied, output settled);
endinterface : atic_slew_if

// File: tb/atic_apb_host.sv
// Bus master model of the external microcontroller
`timescale 1ns/10ps
module atic_apb_host (
    // Clock
    input wire logic core_clk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic er);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= {4{wr}};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : atic_apb_host

// File: tb/atic_ctrl_regs_sva.sv
// Assertion checker for the control register bank
`timescale 1ns/10ps
module atic_ctrl_regs_sva #(
    parameter int NUM_PINS = 15,
    parameter int ADDR_W = 12
) (
    // Clock and bus
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    // Side pins
    input wire logic ampProtectPin,
    input wire atic_pkg::atic_drop_t appliedDrop,
    input wire logic firstBeepEnable,
    input wire logic secondBeepEnable,
    input wire logic [NUM_PINS-1:0] pullupEnable,
    input wire logic [NUM_PINS-1:0] pulldownEnable,
    input wire logic [NUM_PINS-1:0] schmittEnable
);
    import atic_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic ok;
    logic rdAcc;
    logic wrAcc;
    logic inPins;
    logic [7:0] idx;
    logic [7:0] pin;
    assign idx = paddr[9:2];
    assign pin = idx - 8'h87;
    assign ok = psel && penable && paddr[1:0] == 2'h0 && paddr[ADDR_W-1:10] == '0;
    assign rdAcc = ok && !pwrite;
    assign wrAcc = ok && pwrite && pstrb[0];
    assign inPins = idx >= 8'h87 && idx <= 8'h95;
    a_drop_upper: assert property (rdAcc && idx == 8'h63 |-> prdata[31:5] == 27'h0)
        else $error("drop upper bits set");
    a_drop_release: assert property (!ampProtectPin [*6] |-> appliedDrop <= $past(appliedDrop))
        else $error("drop rises with pin low");
    a_tone_write: assert property (wrAcc && idx == 8'h64 |=> firstBeepEnable == $past(pwdata[0]))
        else $error("first tone not written");
    a_tone_second: assert property (wrAcc && idx == 8'h64 |=> secondBeepEnable == $past(pwdata[1]))
        else $error("second tone not written");
    a_tone_upper: assert property (rdAcc && idx == 8'h64 |-> prdata[31:2] == 30'h0)
        else $error("tone upper bits set");
    a_pin_upper: assert property (rdAcc && inPins |-> prdata[31:3] == 29'h0)
        else $error("pin upper bits set");
    a_pin_write: assert property (wrAcc && inPins |=> {pullupEnable[$past(pin)],
        pulldownEnable[$past(pin)], schmittEnable[$past(pin)]} == $past(pwdata[2:0]))
        else $error("pin outputs not written");
    a_slew_step: assert property ($changed(appliedDrop) |->
        atic_drop_t'(appliedDrop - $past(appliedDrop)) inside {5'h01, 5'h1F})
        else $error("drop jumped");
    a_pin_reset: assert property ($rose(rst_n) |-> schmittEnable == 15'h000C)
        else $error("schmitt reset wrong");
    cover property (wrAcc && idx == 8'h63);
    cover property (wrAcc && inPins);
    cover property ($changed(appliedDrop));
endmodule : atic_ctrl_regs_sva

bind atic_ctrl_regs atic_ctrl_regs_sva #(.NUM_PINS(NUM_PINS), .ADDR_W(ADDR_W)) atic_ctrl_regs_sva_i (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .ampProtectPin(ampProtectPin), .appliedDrop(appliedDrop),
    .firstBeepEnable(firstBeepEnable), .secondBeepEnable(secondBeepEnable),
    .pullupEnable(pullupEnable), .pulldownEnable(pulldownEnable), .schmittEnable(schmittEnable)
);

// File: tb/tb_amp_tone_io_control_regs.sv
// Self-checking bench for the control register bank
`timescale 1ns/10ps
module tb_amp_tone_io_control_regs;
    import atic_pkg::*;
    logic core_clk;
    logic rst_n;
    logic psel, penable, pwrite, pready, pslverr, ampProtectPin, dropSettled;
    logic firstBeepEnable, secondBeepEnable;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    atic_period_t profileSlewPeriod;
    atic_drop_t appliedDrop;
    logic [14:0] pullupEnable, pulldownEnable, schmittEnable;
    int badCount = 0;
    int nCompared = 0;
    int cycles = 0;
    atic_ctrl_regs atic_ctrl_regs_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ampProtectPin(ampProtectPin),
        .profileSlewPeriod(profileSlewPeriod), .appliedDrop(appliedDrop),
        .dropSettled(dropSettled), .firstBeepEnable(firstBeepEnable),
        .secondBeepEnable(secondBeepEnable), .pullupEnable(pullupEnable),
        .pulldownEnable(pulldownEnable), .schmittEnable(schmittEnable));
    atic_apb_host atic_apb_host_i (.core_clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    task automatic stopTest();
        if (badCount == 0 && nCompared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stopTest
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rd(input logic [7:0] i, input logic [31:0] exp, input logic eExp);
        logic [31:0] d;
        logic e;
        atic_apb_host_i.xfer(1'b0, {2'h0, i, 2'h0}, 32'h0, d, e);
        check(d, exp);
        check(e, eExp);
    endtask : rd
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        atic_apb_host_i.xfer(1'b1, {2'h0, i, 2'h0}, d, r, e);
    endtask : wr
    task automatic testRegs();
        logic [31:0] d;
        logic e;
        rd(8'h63, 32'h3, 1'b0);
        rd(8'h64, 32'h0, 1'b0);
        rd(8'h70, 32'h0, 1'b1);
        check(schmittEnable, 32'h000C);
        for (int i = 0; i < 15; i++) begin
            rd(8'(8'h87 + i), (i == 2 || i == 3) ? 32'h1 : 32'h0, 1'b0);
        end
        wr(8'h63, 32'hFFFF_FFFF);
        atic_apb_host_i.xfer(1'b0, 12'h18D, 32'h0, d, e);
        check(e, 1'b1);
        check(d, 32'h0);
        atic_apb_host_i.xfer(1'b1, 12'h58C, 32'h0000_0001, d, e);
        check(e, 1'b1);
        rd(8'h63, 32'h1F, 1'b0);
        for (int v = 0; v < 4; v++) begin
            wr(8'h64, 32'(32'hFC | v));
            rd(8'h64, 32'(v), 1'b0);
            check({secondBeepEnable, firstBeepEnable}, 32'(v));
        end
        for (int i = 0; i < 15; i++) begin
            wr(8'(8'h87 + i), 32'(32'hF8 | (i % 8)));
        end
        for (int i = 0; i < 15; i++) begin
            rd(8'(8'h87 + i), 32'(i % 8), 1'b0);
            check({pullupEnable[i], pulldownEnable[i], schmittEnable[i]}, 32'(i % 8));
        end
    endtask : testRegs
    task automatic waitSettled();
        for (int n = 0; n < 80 && dropSettled !== 1'b1; n++) begin
            @(posedge core_clk);
        end
    endtask : waitSettled
    task automatic testAmp();
        wr(8'h63, 32'h5);
        @(posedge core_clk);
        profileSlewPeriod <= 16'h0003;
        ampProtectPin <= 1'b1;
        repeat (2) @(posedge core_clk);
        check(appliedDrop, 32'h0);
        repeat (3) @(posedge core_clk);
        waitSettled();
        check(appliedDrop, 32'h5);
        rd(8'h60, 32'h65, 1'b0);
        ampProtectPin <= 1'b0;
        repeat (8) @(posedge core_clk);
        check(appliedDrop == 5'h00, 32'h0);
        waitSettled();
        check(appliedDrop, 32'h0);
        rd(8'h60, 32'h40, 1'b0);
    endtask : testAmp
    task automatic testReset();
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(8'h63, 32'h3, 1'b0);
        rd(8'h64, 32'h0, 1'b0);
        rd(8'h89, 32'h1, 1'b0);
        check({secondBeepEnable, firstBeepEnable}, 32'h0);
        check(schmittEnable, 32'h000C);
        check(pullupEnable | pulldownEnable, 32'h0);
        check(appliedDrop, 32'h0);
    endtask : testReset
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 10000) begin
            badCount++;
            stopTest();
        end
    end
    initial begin
        rst_n = 1'b0;
        ampProtectPin = 1'b0;
        profileSlewPeriod = 16'h0000;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        testRegs();
        testAmp();
        testReset();
        stopTest();
    end
endmodule : tb_amp_tone_io_control_regs
